/* common/light_regs_defines.vh */
// Address map, field layout, reset values and timing of the user register bank
`ifndef LIGHT_REGS_DEFINES_VH
`define LIGHT_REGS_DEFINES_VH

`define ADDR_W                4
`define DATA_W                8

`define ADDR_ANALOG_CHAIN     4'h0
`define ADDR_CHA_DAC          4'h1
`define ADDR_CHA_FILTER       4'h2
`define ADDR_CHB_DAC          4'h3
`define ADDR_CHB_FILTER       4'h4
`define ADDR_PULSE_FREQ       4'h5
`define ADDR_FAULT_FLAGS      4'h6
`define ADDR_RESET_CAUSE      4'h7
`define ADDR_BUF_GAIN         4'hA
`define ADDR_BANDGAP_TRIM     4'hB
`define ADDR_TEMP_TRIM        4'hC
`define ADDR_CHAN_ENABLES     4'hD
`define ADDR_AMBIENT_TEMP     4'hE

`define RST_ANALOG_CHAIN      8'h05
`define RST_CHA_DAC           8'h00
`define RST_CHA_FILTER        8'h0D
`define RST_CHB_DAC           8'h00
`define RST_CHB_FILTER        8'h0D
`define RST_PULSE_FREQ        8'h44
`define RST_FAULT_FLAGS       8'h00
`define RST_RESET_CAUSE       8'h00
`define RST_BUF_GAIN          8'h00
`define RST_BANDGAP_TRIM      8'h00
`define RST_TEMP_TRIM         8'h00
`define RST_CHAN_ENABLES      8'h00
`define RST_AMBIENT_TEMP      8'h00

`define MASK_FULL             8'hFF
`define MASK_PULSE_FREQ       8'hF7
`define MASK_FAULT_FLAGS      8'h7E
`define MASK_RESET_CAUSE      8'h03
`define MASK_BUF_GAIN         8'h1F
`define MASK_BANDGAP_TRIM     8'hF8
`define MASK_TEMP_TRIM        8'h3F
`define MASK_CHAN_ENABLES     8'hFE
`define MASK_AMBIENT_TEMP     8'h03

`define DEMOD_MSB             7
`define DEMOD_LSB             4
`define LED_HG_BIT            3
`define DC_LEAD_MSB           2
`define DC_LEAD_LSB           1
`define BYPASS_BIT            0
`define AA_GAIN_MSB           7
`define AA_GAIN_LSB           5
`define AA_BW_MSB             4
`define AA_BW_LSB             2
`define LP_SEL_MSB            1
`define LP_SEL_LSB            0
`define BUF_GAIN_MSB          4

`define CLK_MHZ               200
`define DEMOD_STEP_NS         400
`define DEMOD_STEP_CYC        ((`DEMOD_STEP_NS * `CLK_MHZ) / 1000)
`define DC_LEAD_BASE_US       50
`define DC_LEAD_BASE_CYC      (`DC_LEAD_BASE_US * `CLK_MHZ)

`endif

/* core/reg8_cell.v */
// One 8-bit user register with write mask and power-on value
`timescale 1ns/100ps
`default_nettype none
module reg8_cell #(
   parameter [7:0] RST_VAL = 8'h00,
   parameter [7:0] WMASK   = 8'hFF
) (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       ce_i,
   input  wire       we_i,
   input  wire [7:0] wdata_i,
   output wire [7:0] q_o
);
   reg [7:0] val_q;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         val_q <= RST_VAL & WMASK;
      end else if (ce_i && we_i) begin
         val_q <= wdata_i & WMASK;
      end
   end

   assign q_o = val_q;
endmodule // reg8_cell
`default_nettype wire

/* core/light_regs.v */
// User register bank of the active light sensor with analog chain decode
`include "light_regs_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module light_regs #(
   parameter DC_LEAD_BASE_CYC = `DC_LEAD_BASE_CYC
) (
   input  wire        CLK_I,
   input  wire        RST_N_I,
   input  wire        CE_I,
   input  wire        WR_EN_I,
   input  wire        RD_EN_I,
   input  wire [3:0]  ADDR_I,
   input  wire [7:0]  WDATA_I,
   output reg  [7:0]  RDATA_O,
   input  wire        ACTIVE_MEAS_I,
   input  wire        MEAS_START_I,
   input  wire        PULSE_EDGE_I,
   input  wire        SELFTEST_I,
   input  wire        ADC_VALID_I,
   input  wire [15:0] ADC_RESULT_I,
   output reg         LED_HIGH_GAIN_O,
   output reg         BUF_BYPASS_O,
   output reg  [4:0]  BUF_GAIN_O,
   output reg  [7:0]  DAC_INPUT_O,
   output reg         DC_ENABLE_O,
   output reg         PULSES_GO_O,
   output reg         DEMOD_STROBE_O,
   output reg  [10:0] AA_GAIN_CENTI_O,
   output reg  [9:0]  AA_BW_DECI_KHZ_O,
   output reg  [7:0]  LP_DECI_PCT_O,
   output reg  [15:0] SELFTEST_RESULT_O,
   output reg         SELFTEST_DONE_O
);
   localparam NREG = 13;
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_LEAD = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;
   localparam integer DEMOD_STEP_FULL = `DEMOD_STEP_CYC;
   // Counters are 17 and 11 bits; longer settings do not fit
   localparam [16:0] DC_BASE = DC_LEAD_BASE_CYC[16:0];
   localparam [10:0] DEMOD_STEP = DEMOD_STEP_FULL[10:0];

   // Register list, ordered as the address map
   wire [4*NREG-1:0] addr_tab = {
      `ADDR_AMBIENT_TEMP, `ADDR_CHAN_ENABLES, `ADDR_TEMP_TRIM, `ADDR_BANDGAP_TRIM,
      `ADDR_BUF_GAIN, `ADDR_RESET_CAUSE, `ADDR_FAULT_FLAGS, `ADDR_PULSE_FREQ,
      `ADDR_CHB_FILTER, `ADDR_CHB_DAC, `ADDR_CHA_FILTER, `ADDR_CHA_DAC,
      `ADDR_ANALOG_CHAIN};
   wire [8*NREG-1:0] q_flat;
   wire [NREG-1:0]   sel;

   wire [7:0] analog_q  = q_flat[7:0];
   wire [7:0] cha_dac_q = q_flat[15:8];
   wire [7:0] cha_flt_q = q_flat[23:16];
   wire [7:0] bufgain_q = q_flat[71:64];

   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : g_sel
         assign sel[g] = (ADDR_I == addr_tab[4*g+3:4*g]);
      end
   endgenerate

   reg8_cell #(.RST_VAL(`RST_ANALOG_CHAIN), .WMASK(`MASK_FULL)) u_analog (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[0]),
      .wdata_i(WDATA_I), .q_o(q_flat[7:0]));
   reg8_cell #(.RST_VAL(`RST_CHA_DAC), .WMASK(`MASK_FULL)) u_cha_dac (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[1]),
      .wdata_i(WDATA_I), .q_o(q_flat[15:8]));
   reg8_cell #(.RST_VAL(`RST_CHA_FILTER), .WMASK(`MASK_FULL)) u_cha_flt (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[2]),
      .wdata_i(WDATA_I), .q_o(q_flat[23:16]));
   reg8_cell #(.RST_VAL(`RST_CHB_DAC), .WMASK(`MASK_FULL)) u_chb_dac (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[3]),
      .wdata_i(WDATA_I), .q_o(q_flat[31:24]));
   reg8_cell #(.RST_VAL(`RST_CHB_FILTER), .WMASK(`MASK_FULL)) u_chb_flt (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[4]),
      .wdata_i(WDATA_I), .q_o(q_flat[39:32]));
   reg8_cell #(.RST_VAL(`RST_PULSE_FREQ), .WMASK(`MASK_PULSE_FREQ)) u_pulse (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[5]),
      .wdata_i(WDATA_I), .q_o(q_flat[47:40]));
   reg8_cell #(.RST_VAL(`RST_FAULT_FLAGS), .WMASK(`MASK_FAULT_FLAGS)) u_fault (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[6]),
      .wdata_i(WDATA_I), .q_o(q_flat[55:48]));
   reg8_cell #(.RST_VAL(`RST_RESET_CAUSE), .WMASK(`MASK_RESET_CAUSE)) u_rcause (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[7]),
      .wdata_i(WDATA_I), .q_o(q_flat[63:56]));
   reg8_cell #(.RST_VAL(`RST_BUF_GAIN), .WMASK(`MASK_BUF_GAIN)) u_bufgain (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[8]),
      .wdata_i(WDATA_I), .q_o(q_flat[71:64]));
   reg8_cell #(.RST_VAL(`RST_BANDGAP_TRIM), .WMASK(`MASK_BANDGAP_TRIM)) u_bgtrim (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[9]),
      .wdata_i(WDATA_I), .q_o(q_flat[79:72]));
   reg8_cell #(.RST_VAL(`RST_TEMP_TRIM), .WMASK(`MASK_TEMP_TRIM)) u_ttrim (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[10]),
      .wdata_i(WDATA_I), .q_o(q_flat[87:80]));
   reg8_cell #(.RST_VAL(`RST_CHAN_ENABLES), .WMASK(`MASK_CHAN_ENABLES)) u_chen (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[11]),
      .wdata_i(WDATA_I), .q_o(q_flat[95:88]));
   reg8_cell #(.RST_VAL(`RST_AMBIENT_TEMP), .WMASK(`MASK_AMBIENT_TEMP)) u_tamb (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .we_i(WR_EN_I & sel[12]),
      .wdata_i(WDATA_I), .q_o(q_flat[103:96]));

   // Read mux; an unmapped address matches nothing and reads zero
   reg [7:0] rd_mux;
   integer i;
   always @* begin
      rd_mux = 8'h00;
      for (i = 0; i < NREG; i = i + 1) begin
         if (sel[i]) begin
            rd_mux = rd_mux | q_flat[8*i +: 8];
         end
      end
   end

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RDATA_O <= 8'h00;
      end else if (CE_I && RD_EN_I) begin
         RDATA_O <= rd_mux;
      end
   end

   // Filter code decode in fixed point: centi-gain, 0.1 kHz, 0.1 percent
   wire [2:0] aa_gain_code = cha_flt_q[`AA_GAIN_MSB:`AA_GAIN_LSB];
   wire [2:0] aa_bw_code   = cha_flt_q[`AA_BW_MSB:`AA_BW_LSB];
   wire [1:0] lp_code      = cha_flt_q[`LP_SEL_MSB:`LP_SEL_LSB];
   reg  [10:0] gain_d;
   reg  [9:0]  bw_d;
   reg  [7:0]  lp_d;

   always @* begin
      case (aa_gain_code)
         3'h0:    gain_d = 11'd200;
         3'h1:    gain_d = 11'd429;
         3'h2:    gain_d = 11'd657;
         3'h3:    gain_d = 11'd886;
         3'h4:    gain_d = 11'd1114;
         3'h5:    gain_d = 11'd1343;
         3'h6:    gain_d = 11'd1571;
         default: gain_d = 11'd1800;
      endcase
      case (aa_bw_code)
         3'h0:    bw_d = 10'd180;
         3'h1:    bw_d = 10'd200;
         3'h2:    bw_d = 10'd225;
         3'h3:    bw_d = 10'd250;
         3'h4:    bw_d = 10'd300;
         3'h5:    bw_d = 10'd350;
         3'h6:    bw_d = 10'd430;
         default: bw_d = 10'd550;
      endcase
      case (lp_code)
         2'h0:    lp_d = 8'd235;
         2'h1:    lp_d = 8'd120;
         2'h2:    lp_d = 8'd59;
         default: lp_d = 8'd30;
      endcase
   end

   // Static analog settings registered so the analog side sees clean levels
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         LED_HIGH_GAIN_O  <= 1'b0;
         BUF_BYPASS_O     <= 1'b0;
         BUF_GAIN_O       <= 5'h00;
         DAC_INPUT_O      <= 8'h00;
         AA_GAIN_CENTI_O  <= 11'd0;
         AA_BW_DECI_KHZ_O <= 10'd0;
         LP_DECI_PCT_O    <= 8'd0;
      end else if (CE_I) begin
         LED_HIGH_GAIN_O  <= analog_q[`LED_HG_BIT];
         BUF_BYPASS_O     <= ACTIVE_MEAS_I & analog_q[`BYPASS_BIT];
         BUF_GAIN_O       <= (ACTIVE_MEAS_I & analog_q[`BYPASS_BIT]) ?
                             5'h00 : bufgain_q[`BUF_GAIN_MSB:0];
         DAC_INPUT_O      <= cha_dac_q;
         AA_GAIN_CENTI_O  <= gain_d;
         AA_BW_DECI_KHZ_O <= bw_d;
         LP_DECI_PCT_O    <= lp_d;
      end
   end

   // DC lead sequencer; lead length doubles with each code step
   reg [1:0]  state_q;
   reg [16:0] lead_cnt_q;
   wire [1:0]  lead_code = analog_q[`DC_LEAD_MSB:`DC_LEAD_LSB];
   wire [16:0] lead_len  = DC_BASE << lead_code;

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q     <= ST_IDLE;
         lead_cnt_q  <= 17'd0;
         DC_ENABLE_O <= 1'b0;
         PULSES_GO_O <= 1'b0;
      end else if (CE_I) begin
         PULSES_GO_O <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (MEAS_START_I) begin
                  state_q     <= ST_LEAD;
                  lead_cnt_q  <= lead_len - 17'd1;
                  DC_ENABLE_O <= 1'b1;
               end
            end
            ST_LEAD: begin
               if (lead_cnt_q == 17'd0) begin
                  state_q     <= ST_RUN;
                  PULSES_GO_O <= 1'b1;
               end else begin
                  lead_cnt_q <= lead_cnt_q - 17'd1;
               end
            end
            ST_RUN: begin
               if (!ACTIVE_MEAS_I) begin
                  state_q     <= ST_IDLE;
                  DC_ENABLE_O <= 1'b0;
               end
            end
            default: begin
               state_q     <= ST_IDLE;
               DC_ENABLE_O <= 1'b0;
            end
         endcase
      end
   end

   // Demodulator delay; code zero strobes on the same edge that samples the pulse edge
   reg [10:0] demod_cnt_q;
   reg        demod_busy_q;
   wire [3:0]  demod_code = analog_q[`DEMOD_MSB:`DEMOD_LSB];
   wire [14:0] demod_prod = demod_code * DEMOD_STEP;
   wire [10:0] demod_len  = demod_prod[10:0];

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         demod_cnt_q    <= 11'd0;
         demod_busy_q   <= 1'b0;
         DEMOD_STROBE_O <= 1'b0;
      end else if (CE_I) begin
         DEMOD_STROBE_O <= 1'b0;
         if (PULSE_EDGE_I) begin
            if (demod_len == 11'd0) begin
               DEMOD_STROBE_O <= 1'b1;
               demod_busy_q   <= 1'b0;
            end else begin
               demod_cnt_q  <= demod_len - 11'd1;
               demod_busy_q <= 1'b1;
            end
         end else if (demod_busy_q) begin
            if (demod_cnt_q == 11'd0) begin
               DEMOD_STROBE_O <= 1'b1;
               demod_busy_q   <= 1'b0;
            end else begin
               demod_cnt_q <= demod_cnt_q - 11'd1;
            end
         end
      end
   end

   // Self test capture of the reconverted ADC value
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SELFTEST_RESULT_O <= 16'h0000;
         SELFTEST_DONE_O   <= 1'b0;
      end else if (CE_I) begin
         SELFTEST_DONE_O <= 1'b0;
         if (SELFTEST_I && ADC_VALID_I) begin
            SELFTEST_RESULT_O <= ADC_RESULT_I;
            SELFTEST_DONE_O   <= 1'b1;
         end
      end
   end
endmodule // light_regs
`default_nettype wire

/* dv/light_regs_checker.sv */
// Port-level assertion checker for the user register bank
`timescale 1ns/100ps
`default_nettype none
module light_regs_checker #(
   parameter DC_LEAD_BASE_CYC = 10000
) (
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        CE_I,
   input wire logic        WR_EN_I,
   input wire logic        RD_EN_I,
   input wire logic [3:0]  ADDR_I,
   input wire logic [7:0]  WDATA_I,
   input wire logic [7:0]  RDATA_O,
   input wire logic        ACTIVE_MEAS_I,
   input wire logic        MEAS_START_I,
   input wire logic        SELFTEST_I,
   input wire logic        ADC_VALID_I,
   input wire logic [15:0] ADC_RESULT_I,
   input wire logic        LED_HIGH_GAIN_O,
   input wire logic        BUF_BYPASS_O,
   input wire logic [4:0]  BUF_GAIN_O,
   input wire logic [7:0]  DAC_INPUT_O,
   input wire logic        DC_ENABLE_O,
   input wire logic        PULSES_GO_O,
   input wire logic [15:0] SELFTEST_RESULT_O,
   input wire logic        SELFTEST_DONE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   a_dac_follows: assert property (
      (CE_I && WR_EN_I && ADDR_I == 4'h1) ##1 CE_I |=> DAC_INPUT_O == $past(WDATA_I, 2))
      else $error("dac input not the written level");
   a_led_follows: assert property (
      (CE_I && WR_EN_I && ADDR_I == 4'h0) ##1 CE_I |=> LED_HIGH_GAIN_O == $past(WDATA_I[3], 2))
      else $error("led gain not the written bit");
   a_unmapped_reads: assert property (
      (CE_I && RD_EN_I && (ADDR_I == 4'h8 || ADDR_I == 4'h9 || ADDR_I == 4'hF))
      |=> RDATA_O == 8'h00) else $error("unassigned address read nonzero");
   a_rdata_holds: assert property (!(CE_I && RD_EN_I) |=> $stable(RDATA_O))
      else $error("read data moved without a read");
   a_bypass_gated: assert property ((CE_I && !ACTIVE_MEAS_I) |=> !BUF_BYPASS_O)
      else $error("bypass outside active measurement");
   a_gain_when_bypass: assert property (BUF_BYPASS_O |-> BUF_GAIN_O == 5'h0)
      else $error("buffer gain nonzero while bypassed");
   a_lead_starts: assert property (
      (CE_I && MEAS_START_I && !DC_ENABLE_O) |=> DC_ENABLE_O)
      else $error("dc enable did not rise on start");
   a_go_single: assert property ((PULSES_GO_O && CE_I) |-> DC_ENABLE_O ##1 !PULSES_GO_O)
      else $error("pulse start not a single cycle in lead");
   a_test_capture: assert property (
      (CE_I && SELFTEST_I && ADC_VALID_I)
      |=> SELFTEST_DONE_O && SELFTEST_RESULT_O == $past(ADC_RESULT_I))
      else $error("self test result not captured");
   a_done_cause: assert property (
      (SELFTEST_DONE_O && $past(CE_I)) |-> $past(SELFTEST_I && ADC_VALID_I))
      else $error("self test done without a conversion");
endmodule // light_regs_checker
bind light_regs light_regs_checker #(.DC_LEAD_BASE_CYC(DC_LEAD_BASE_CYC)) u_chk (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .WR_EN_I(WR_EN_I), .RD_EN_I(RD_EN_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .ACTIVE_MEAS_I(ACTIVE_MEAS_I),
   .MEAS_START_I(MEAS_START_I), .SELFTEST_I(SELFTEST_I), .ADC_VALID_I(ADC_VALID_I),
   .ADC_RESULT_I(ADC_RESULT_I), .LED_HIGH_GAIN_O(LED_HIGH_GAIN_O),
   .BUF_BYPASS_O(BUF_BYPASS_O), .BUF_GAIN_O(BUF_GAIN_O), .DAC_INPUT_O(DAC_INPUT_O),
   .DC_ENABLE_O(DC_ENABLE_O), .PULSES_GO_O(PULSES_GO_O),
   .SELFTEST_RESULT_O(SELFTEST_RESULT_O), .SELFTEST_DONE_O(SELFTEST_DONE_O));
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the user register bank
`timescale 1ns/100ps
`default_nettype none
`include "light_regs_defines.vh"
module tb_top;
   localparam int LEAD = 4;
   logic CLK_I = 1'b0, RST_N_I = 1'b0, CE_I = 1'b1, WR_EN_I = 1'b0, RD_EN_I = 1'b0;
   logic ACTIVE_MEAS_I = 1'b0, MEAS_START_I = 1'b0, PULSE_EDGE_I = 1'b0;
   logic SELFTEST_I = 1'b0, ADC_VALID_I = 1'b0, ce;
   logic [3:0] ADDR_I = 4'h0, a4;
   logic [7:0] WDATA_I = 8'h00, d, mdl[16];
   logic [15:0] ADC_RESULT_I = 16'h0000;
   wire [7:0] RDATA_O, DAC_INPUT_O, LP_DECI_PCT_O;
   wire LED_HIGH_GAIN_O, BUF_BYPASS_O, DC_ENABLE_O, PULSES_GO_O, DEMOD_STROBE_O, SELFTEST_DONE_O;
   wire [4:0] BUF_GAIN_O;
   wire [10:0] AA_GAIN_CENTI_O;
   wire [9:0] AA_BW_DECI_KHZ_O;
   wire [15:0] SELFTEST_RESULT_O;
   int n_fail = 0, n_checks = 0, seed, cyc = 0, n;
   int bw[8] = '{180, 200, 225, 250, 300, 350, 430, 550};
   int lp[4] = '{235, 120, 59, 30};
   light_regs #(.DC_LEAD_BASE_CYC(LEAD)) DUT (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
      .WR_EN_I(WR_EN_I), .RD_EN_I(RD_EN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .RDATA_O(RDATA_O), .ACTIVE_MEAS_I(ACTIVE_MEAS_I), .MEAS_START_I(MEAS_START_I),
      .PULSE_EDGE_I(PULSE_EDGE_I), .SELFTEST_I(SELFTEST_I), .ADC_VALID_I(ADC_VALID_I),
      .ADC_RESULT_I(ADC_RESULT_I), .LED_HIGH_GAIN_O(LED_HIGH_GAIN_O),
      .BUF_BYPASS_O(BUF_BYPASS_O), .BUF_GAIN_O(BUF_GAIN_O), .DAC_INPUT_O(DAC_INPUT_O),
      .DC_ENABLE_O(DC_ENABLE_O), .PULSES_GO_O(PULSES_GO_O), .DEMOD_STROBE_O(DEMOD_STROBE_O),
      .AA_GAIN_CENTI_O(AA_GAIN_CENTI_O), .AA_BW_DECI_KHZ_O(AA_BW_DECI_KHZ_O),
      .LP_DECI_PCT_O(LP_DECI_PCT_O), .SELFTEST_RESULT_O(SELFTEST_RESULT_O),
      .SELFTEST_DONE_O(SELFTEST_DONE_O));
   always #2.5 CLK_I = ~CLK_I;
   function automatic logic [7:0] rv(input int a);
      case (a)
         0: return 8'h05;
         2, 4: return 8'h0D;
         5: return 8'h44;
         default: return 8'h00;
      endcase
   endfunction
   // Unassigned places have an all-zero mask, so they always read zero
   function automatic logic [7:0] mk(input int a);
      case (a)
         0, 1, 2, 3, 4: return 8'hFF;
         5: return 8'hF7;
         6: return 8'h7E;
         7, 14: return 8'h03;
         10: return 8'h1F;
         11: return 8'hF8;
         12: return 8'h3F;
         13: return 8'hFE;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic e);
      @(posedge CLK_I);
      CE_I <= e;
      WR_EN_I <= 1'b1;
      ADDR_I <= a;
      WDATA_I <= v;
      @(posedge CLK_I);
      CE_I <= 1'b1;
      WR_EN_I <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge CLK_I);
      RD_EN_I <= 1'b1;
      ADDR_I <= a;
      @(posedge CLK_I);
      RD_EN_I <= 1'b0;
      #1 v = RDATA_O;
   endtask
   task automatic sweep;
      for (int a = 0; a < 16; a++) begin
         rd(a[3:0], d);
         chk("rdata", d, mdl[a]);
      end
   endtask
   task automatic settle;
      repeat (2) @(posedge CLK_I);
      #1;
   endtask
   // Counts edges from the trigger edge until the chosen strobe shows
   task automatic cnt(input logic sel);
      n = 0;
      #1;
      while ((sel ? DEMOD_STROBE_O : PULSES_GO_O) !== 1'b1 && n < 2000) begin
         @(posedge CLK_I);
         #1;
         n++;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Generous ceiling; the longest delay sweep needs a few thousand cycles
   always @(posedge CLK_I) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   initial begin
      seed = 32'h64e1;
      repeat (3) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      for (int a = 0; a < 16; a++) mdl[a] = rv(a);
      sweep;
      chk("aa gain", AA_GAIN_CENTI_O, 200);
      chk("aa bw", AA_BW_DECI_KHZ_O, 250);
      chk("lowpass", LP_DECI_PCT_O, 120);
      chk("led gain", LED_HIGH_GAIN_O, 0);
      for (int i = 0; i < 80; i++) begin
         a4 = 4'($random(seed));
         d = 8'($random(seed));
         ce = ($random(seed) & 7) != 0;
         wr(a4, d, ce);
         if (ce) mdl[a4] = d & mk(a4);
         a4 = 4'($random(seed));
         rd(a4, d);
         chk("rdata", d, mdl[a4]);
      end
      sweep;
      for (int c = 0; c < 8; c++) begin
         @(posedge CLK_I);
         ACTIVE_MEAS_I <= c[1];
         wr(4'h2, {c[2:0], c[2:0] ^ 3'h5, c[1:0]}, 1'b1);
         wr(4'h0, {4'h0, c[0], 2'b10, c[2]}, 1'b1);
         wr(4'hA, 8'($random(seed)), 1'b1);
         mdl[10] = WDATA_I;
         wr(4'h1, 8'($random(seed)), 1'b1);
         settle;
         chk("aa gain", AA_GAIN_CENTI_O, 200 + (c * 1600 + 3) / 7);
         chk("aa bw", AA_BW_DECI_KHZ_O, bw[c ^ 5]);
         chk("lowpass", LP_DECI_PCT_O, lp[c & 3]);
         chk("led gain", LED_HIGH_GAIN_O, c & 1);
         chk("dac input", DAC_INPUT_O, WDATA_I);
         chk("bypass", BUF_BYPASS_O, c[1] & c[2]);
         chk("buf gain", BUF_GAIN_O, (c[1] & c[2]) ? 5'h0 : mdl[10][4:0]);
      end
      for (int code = 0; code < 4; code++) begin
         wr(4'h0, {5'h00, code[1:0], 1'b0}, 1'b1);
         @(posedge CLK_I);
         ACTIVE_MEAS_I <= 1'b1;
         MEAS_START_I <= 1'b1;
         @(posedge CLK_I);
         MEAS_START_I <= 1'b0;
         cnt(1'b0);
         chk("lead cycles", n, LEAD << code);
         chk("dc enable", DC_ENABLE_O, 1);
         @(posedge CLK_I);
         ACTIVE_MEAS_I <= 1'b0;
         settle;
         chk("dc idle", DC_ENABLE_O, 0);
      end
      for (int k = 0; k < 16; k += 5) begin
         wr(4'h0, {k[3:0], 4'h5}, 1'b1);
         @(posedge CLK_I);
         PULSE_EDGE_I <= 1'b1;
         @(posedge CLK_I);
         PULSE_EDGE_I <= 1'b0;
         cnt(1'b1);
         chk("demod cycles", n, k * `DEMOD_STEP_CYC);
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge CLK_I);
         SELFTEST_I <= 1'b1;
         ADC_VALID_I <= 1'b1;
         ADC_RESULT_I <= 16'($random(seed));
         @(posedge CLK_I);
         ADC_VALID_I <= 1'b0;
         #1;
         chk("test result", SELFTEST_RESULT_O, ADC_RESULT_I);
         chk("test done", SELFTEST_DONE_O, 1);
      end
      // Second reset from a dirty state must restore power-on values
      RST_N_I <= 1'b0;
      repeat (3) @(posedge CLK_I);
      chk("dac in reset", DAC_INPUT_O, 0);
      chk("rdata in reset", RDATA_O, 0);
      RST_N_I <= 1'b1;
      for (int a = 0; a < 16; a++) mdl[a] = rv(a);
      sweep;
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire
